// file: rtl/cim_map.svh
// Register offsets, field positions and reset values of the mask/status block
// Operation
// - Bits 7..1 at sub address 0x05 give thermistor code, read only.
// - Mask bit 7 enables charger state change interrupts; resets to 0.
// - Mask bit 6 enables fault flag change interrupts; resets to 0.
// - Mask bit 5 enables primary, secondary and external power flag interrupts; resets to 0.
// - A write to 0x06 clears the pending request unless an enabled event lands in the same cycle; mask reads back.
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH
`define CIM_ADDR_THERM 8'h05
`define CIM_ADDR_MASK 8'h06
`define CIM_MASK_RESET 8'h00
`define CIM_BIT_CHG_EN 7
`define CIM_BIT_FLT_EN 6
`define CIM_BIT_PWR_EN 5
`define CIM_BIT_WARN 0
`define CIM_CODE_LSB 1
`define CIM_RDATA_RESET 8'h00
`define CIM_UNMAPPED_DATA 8'h00
`endif

// file: rtl/cim_pkg.sv
// Types shared by the mask/status block
package cim_pkg;
  typedef logic [7:0] cim_byte_t;
  typedef logic [2:0] cim_chg_state_t;
  typedef logic [3:0] cim_fault_t;
  typedef logic [2:0] cim_power_t;
endpackage

// file: rtl/cim_change_det.sv
// Change detector: flags any difference from the previous sample
`timescale 1ns/10ps
module cim_change_det #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Observed flags
  input wire logic [WIDTH-1:0] flags,
  output logic changed
);
  logic [WIDTH-1:0] last;
  logic primed;
  logic [WIDTH-1:0] next_last;
  logic next_primed;

  always_comb begin
    next_last = flags;
    next_primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      last <= '0;
      primed <= 1'b0;
    end else if (clkEn) begin
      last <= next_last;
      primed <= next_primed;
    end
  end

  // First sample after reset only seeds the history
  assign changed = primed && (flags != last);
endmodule

// file: rtl/cim_irq_status.sv
// Thermistor result register, interrupt mask register and pending request
`timescale 1ns/10ps
`include "cim_map.svh"
module cim_irq_status
  import cim_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register port from the serial bus engine
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Charger monitors
  input wire logic [6:0] thermistorCode,
  input wire logic tempTooHot,
  input wire logic tempTooCold,
  input wire logic [2:0] chargerState,
  input wire logic overvoltageFlag,
  input wire logic badCellFlag,
  input wire logic boostFaultFlag,
  input wire logic thermistorHotFlag,
  input wire logic primaryInputGood,
  input wire logic secondaryInputGood,
  input wire logic extPowerGood,
  // Interrupt request, active high level
  output logic irqPending
);
  cim_byte_t mask;
  cim_byte_t next_mask;
  logic next_pending;
  cim_byte_t next_rdata;
  cim_byte_t thermByte;
  logic chgChanged;
  logic fltChanged;
  logic pwrChanged;
  logic eventAny;
  logic maskWrite;
  logic tempOutOfRangeFlag;
  cim_fault_t faultFlags;
  cim_power_t powerFlags;

  // Shared by the write decode and the read decode
  function automatic logic addrIs(input logic [7:0] addr,
                                  input logic [7:0] target);
    return addr == target;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Monitor inputs
  assign faultFlags = {overvoltageFlag, badCellFlag, boostFaultFlag,
                       thermistorHotFlag};
  assign powerFlags = {primaryInputGood, secondaryInputGood, extPowerGood};
  assign tempOutOfRangeFlag = tempTooHot | tempTooCold;
  assign thermByte = {thermistorCode, tempOutOfRangeFlag};
  assign maskWrite = regWrite && addrIs(regAddr, `CIM_ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Change detectors, one per interrupt source group
  // History runs even while a group is masked, so enabling a group
  // later never reports a stale change
  cim_change_det #(
    .WIDTH(3)
  ) uChg (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .flags(chargerState),
    .changed(chgChanged)
  );

  cim_change_det #(
    .WIDTH(4)
  ) uFlt (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .flags(faultFlags),
    .changed(fltChanged)
  );

  cim_change_det #(
    .WIDTH(3)
  ) uPwr (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .flags(powerFlags),
    .changed(pwrChanged)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask register
  always_comb begin
    next_mask = mask;
    if (maskWrite) begin
      next_mask = regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask <= `CIM_MASK_RESET;
    end else if (clkEn) begin
      mask <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending request
  // The old mask gates events in the write cycle; the new one acts after
  always_comb begin
    eventAny = (mask[`CIM_BIT_CHG_EN] && chgChanged)
            || (mask[`CIM_BIT_FLT_EN] && fltChanged)
            || (mask[`CIM_BIT_PWR_EN] && pwrChanged);
    // A new event in the clearing cycle wins, so nothing is lost
    if (eventAny) begin
      next_pending = 1'b1;
    end else if (maskWrite) begin
      next_pending = 1'b0;
    end else begin
      next_pending = irqPending;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irqPending <= 1'b0;
    end else if (clkEn) begin
      irqPending <= next_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Held between reads so a slow bus engine may pick it up late
  always_comb begin
    next_rdata = regRdata;
    if (regRead) begin
      if (addrIs(regAddr, `CIM_ADDR_THERM)) begin
        next_rdata = thermByte;
      end else if (addrIs(regAddr, `CIM_ADDR_MASK)) begin
        next_rdata = mask;
      end else begin
        next_rdata = `CIM_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= `CIM_RDATA_RESET;
    end else if (clkEn) begin
      regRdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Reset behaviour
  chk_mask_reset_zero: assert property (@(posedge clk)
    $rose(resetn) |-> mask == `CIM_MASK_RESET)
    else $error("mask not zero after reset");
  chk_reset_clears: assert property (@(posedge clk)
    !resetn |=> !irqPending && regRdata == `CIM_RDATA_RESET
    && mask == `CIM_MASK_RESET)
    else $error("state not cleared by reset");
  chk_seed_quiet: assert property (@(posedge clk)
    $rose(resetn) |-> !chgChanged && !fltChanged && !pwrChanged)
    else $error("false change right after reset");

  // Mask register
  chk_mask_readback: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && maskWrite |=> mask == $past(regWdata))
    else $error("mask not stored");
  chk_mask_other: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && regWrite && regAddr != `CIM_ADDR_MASK
    |=> $stable(mask))
    else $error("mask changed by other write");
  chk_freeze_state: assert property (@(posedge clk)
    disable iff (!resetn) !clkEn |=> $stable(mask) && $stable(irqPending)
    && $stable(regRdata))
    else $error("state moved while enable low");

  // Pending request
  chk_write_clears: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && maskWrite && !eventAny |=> !irqPending)
    else $error("mask write did not clear request");
  chk_set_wins: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && maskWrite && eventAny |=> irqPending)
    else $error("event lost in clearing cycle");
  chk_pending_holds: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && irqPending && !maskWrite |=> irqPending)
    else $error("request dropped without write");
  chk_chg_raises: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && mask[`CIM_BIT_CHG_EN] && chgChanged
    |=> irqPending)
    else $error("charger change missed");
  chk_flt_raises: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && mask[`CIM_BIT_FLT_EN] && fltChanged
    |=> irqPending)
    else $error("fault change missed");
  chk_pwr_raises: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && mask[`CIM_BIT_PWR_EN] && pwrChanged
    |=> irqPending)
    else $error("power change missed");
  chk_no_spurious: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && !irqPending && !eventAny |=> !irqPending)
    else $error("request rose without event");
  chk_masked_quiet: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && !irqPending && !mask[`CIM_BIT_CHG_EN]
    && !mask[`CIM_BIT_FLT_EN] && !mask[`CIM_BIT_PWR_EN] |=> !irqPending)
    else $error("request rose with all groups masked");

  // Read data
  chk_therm_read: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && regRead && regAddr == `CIM_ADDR_THERM
    |=> regRdata[7:`CIM_CODE_LSB] == $past(thermistorCode))
    else $error("thermistor code read wrong");
  chk_warn_bit: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && regRead && regAddr == `CIM_ADDR_THERM
    |=> regRdata[`CIM_BIT_WARN] == $past(tempTooHot | tempTooCold))
    else $error("range warning read wrong");
  chk_mask_read: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && regRead && regAddr == `CIM_ADDR_MASK
    |=> regRdata == $past(mask))
    else $error("mask read back wrong");
  chk_unmapped_zero: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && regRead && regAddr != `CIM_ADDR_THERM
    && regAddr != `CIM_ADDR_MASK |=> regRdata == `CIM_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (@(posedge clk)
    disable iff (!resetn) clkEn && !regRead |=> $stable(regRdata))
    else $error("read data moved without read");
endmodule

// file: test/cim_host.sv
// Host model driving the block's register port
`timescale 1ns/10ps
module cim_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata
);
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Call at a falling edge; the idle cycle keeps strobes apart
  task automatic xfer(input logic w, input logic [7:0] a, d);
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    @(negedge clk);
  endtask
endmodule

// file: test/tb_charger_irq_mask_ntc_status.sv
// Bench for the thermistor status and interrupt mask block
`timescale 1ns/10ps
module tb_charger_irq_mask_ntc_status
  import cim_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, hot = 1'b0, cold = 1'b0, rdLate = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regWrite, regRead, irqPending;
  logic [6:0] code = 7'h00;
  cim_chg_state_t chg = 3'h0;
  cim_fault_t flt = 4'h0;
  cim_power_t pwr = 3'h0;
  cim_byte_t expQ[$];
  cim_byte_t m;
  int fails = 0, checks = 0, seed = 32'h8415, n;
  always #25 clk = ~clk;
  cim_host host_u (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata));
  cim_irq_status dut_u (.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .thermistorCode(code),
    .tempTooHot(hot), .tempTooCold(cold), .chargerState(chg),
    .overvoltageFlag(flt[0]), .badCellFlag(flt[1]),
    .boostFaultFlag(flt[2]), .thermistorHotFlag(flt[3]),
    .primaryInputGood(pwr[0]), .secondaryInputGood(pwr[1]),
    .extPowerGood(pwr[2]), .irqPending(irqPending));
  task automatic cmp(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdx(input logic [7:0] a, exp);
    expQ.push_back(exp);
    host_u.xfer(1'b0, a, 8'h00);
  endtask
  // Change one flag group, then let one sampling edge pass
  task automatic bump(input int g);
    if (g == 0) chg = chg + 3'h1;
    else if (g == 1) flt = flt ^ 4'(1 << ($random(seed) & 3));
    else pwr = pwr ^ 3'(1 << (($random(seed) & 255) % 3));
    @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Read data is registered: compare at the fall after the read edge
  always @(posedge clk) rdLate <= regRead;
  always @(negedge clk) begin
    if (rdLate === 1'b1) cmp(regRdata, expQ.pop_front());
  end
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    rdx(8'h06, 8'h00);
    for (n = 0; n < 4; n++) begin
      code = 7'($random(seed));
      {hot, cold} = 2'(n);
      host_u.xfer(1'b1, 8'h05, 8'h5A);
      rdx(8'h05, {code, n != 0});
    end
    for (n = 0; n < 3; n++) begin
      m = (8'h80 >> n) | 8'h15;
      host_u.xfer(1'b1, 8'h06, m);
      bump((n + 1) % 3);
      cmp(irqPending, 8'h00);
      bump(n);
      cmp(irqPending, 8'h01);
      rdx(8'h06, m);
      host_u.xfer(1'b1, 8'h06, 8'h00);
      cmp(irqPending, 8'h00);
      bump(n);
      cmp(irqPending, 8'h00);
    end
    // A write while the enable is low must not land
    clkEn = 1'b0;
    host_u.xfer(1'b1, 8'h06, 8'hFF);
    clkEn = 1'b1;
    rdx(8'h06, 8'h00);
    // Reset in mid-run drops the request and the mask
    host_u.xfer(1'b1, 8'h06, 8'h80);
    bump(0);
    cmp(irqPending, 8'h01);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    cmp(irqPending, 8'h00);
    rdx(8'h06, 8'h00);
    bump(0);
    cmp(irqPending, 8'h00);
    rdx(8'h07, 8'h00);
    for (n = 0; n < 8 && expQ.size() > 0; n++) @(negedge clk);
    if (expQ.size() > 0) fails++;
    print_verdict();
  end
endmodule
